// ### dv/pin_source.sv
// Purpose: Far-side pin driver for the timer inputs.
// Assumes: Pulses are long enough for the three-stage synchroniser.
// Notes:   Pins idle low between pulses.
`timescale 1ns/100ps
module pin_source (
  // Clock
  input wire logic clock,
  // Pins
  output logic [7:0] ins
);
  initial ins = 8'h00;
  task automatic pulse(input int unsigned pin);
    @(posedge clock);
    ins[pin] <= 1'b1;
    repeat (8) @(posedge clock);
    ins[pin] <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule

// ### dv/state_event_pwm_timer_checker.sv
// Purpose: Port-level assertions for the state/event timer.
// Assumes: Bound to every timer instance.
// Notes:   Judges only what the design drives.
`timescale 1ns/100ps
`include "evt_timer_consts.svh"
module state_event_pwm_timer_checker #(
  parameter int N_EV = `ST_NUM_EV
) (
  input wire logic                   clock,
  input wire logic                   rstn,
  input wire logic                   unify,
  input wire logic [1:0]             halt_release,
  input wire logic [`ST_NUM_OUT-1:0] outs,
  input wire logic [`ST_HALF_W-1:0]  count_lo,
  input wire logic [1:0]             running,
  input wire logic [1:0]             halted,
  input wire logic [`ST_STATE_W-1:0] state,
  input wire logic [N_EV-1:0]        event_fired,
  input wire logic                   irq_req,
  input wire logic                   dma_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence quiet;
    event_fired == '0;
  endsequence
  sequence held_half;
    halted[0] && !halt_release[0];
  endsequence
  halt_hold_a: assert property (held_half |=> halted[0]) else $error("halt lost");
  halt_block_a: assert property (held_half |=> !running[0]) else $error("halted runs");
  count_still_a: assert property (!running[0] |=> $stable(count_lo)) else $error("idle count moved");
  state_hold_a: assert property (quiet |-> $stable(state)) else $error("state moved");
  outs_hold_a: assert property (quiet |-> $stable(outs)) else $error("outputs moved");
  irq_cause_a: assert property (irq_req |-> event_fired != '0) else $error("stray irq");
  dma_cause_a: assert property (dma_req |-> event_fired != '0) else $error("stray dma");
  unify_run_a: assert property (unify |-> running[1] == running[0]) else $error("halves differ");
endmodule
bind state_event_pwm_timer state_event_pwm_timer_checker #(.N_EV(N_EV)) chk (.clock, .rstn, .unify,
  .halt_release, .outs, .count_lo, .running, .halted, .state, .event_fired, .irq_req, .dma_req);

// ### dv/state_event_pwm_timer_tb_top.sv
// Purpose: Directed scenarios for the state/event PWM timer.
// Assumes: Pin model drives the inputs.
// Notes:   Each scenario resets the block and sets its own events.
`timescale 1ns/100ps
`include "evt_timer_consts.svh"
module state_event_pwm_timer_tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic unify = 1'b1;
  logic [1:0] sw_start = 2'h0;
  logic [1:0] halt_release = 2'h0;
  logic [`ST_NUM_EV-1:0] ev_enable;
  logic [`ST_NUM_MC-1:0] cap_mode;
  evt_timer_pkg::ctr_cfg_t ctr_cfg [2];
  evt_timer_pkg::ev_cfg_t ev_cfg [`ST_NUM_EV];
  logic [`ST_CNT_W-1:0] match_value [`ST_NUM_MC];
  evt_timer_pkg::out_res_t out_res [`ST_NUM_OUT];
  logic [`ST_NUM_IN-1:0] ins;
  logic [`ST_NUM_OUT-1:0] outs;
  logic [`ST_HALF_W-1:0] count_lo, count_hi;
  logic [1:0] count_down, running, halted;
  logic [`ST_STATE_W-1:0] state;
  logic [`ST_CNT_W-1:0] capture_value [`ST_NUM_MC];
  logic [`ST_NUM_EV-1:0] event_fired;
  logic irq_req, dma_req;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  state_event_pwm_timer dut (.clock, .rstn, .unify, .ctr_cfg, .sw_start, .halt_release, .ev_enable, .ev_cfg,
    .cap_mode, .match_value, .out_res, .ins, .outs, .count_lo, .count_hi, .count_down, .running, .halted,
    .state, .capture_value, .event_fired, .irq_req, .dma_req);
  pin_source pins (.clock, .ins);
  always #5 clock = ~clock;
  // Hang guard: the five scenarios need well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic clear_cfg();
    rstn <= 1'b0;
    ev_enable <= '0;
    cap_mode <= '0;
    ctr_cfg[0] <= '0;
    ctr_cfg[1] <= '0;
    for (int i = 0; i < `ST_NUM_EV; i++) ev_cfg[i] <= '0;
    for (int i = 0; i < `ST_NUM_MC; i++) match_value[i] <= '0;
    for (int i = 0; i < `ST_NUM_OUT; i++) out_res[i] <= evt_timer_pkg::RES_NONE;
  endtask
  // Events only act while running, so release the halt and start both halves
  task automatic restart();
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    halt_release <= 2'h3;
    @(posedge clock);
    halt_release <= 2'h0;
    sw_start <= 2'h3;
    @(posedge clock);
    sw_start <= 2'h0;
  endtask
  task automatic wait_fire(input int idx);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while (event_fired[idx] !== 1'b1 && n < 300);
    check("event fired", event_fired[idx], 1);
  endtask
  task automatic match_event(input int e, input logic [3:0] sel, input logic [31:0] mask);
    ev_cfg[e].state_mask <= mask;
    ev_cfg[e].match_sel <= sel;
    ev_cfg[e].match_en <= 1'b1;
    ev_cfg[e].comb <= evt_timer_pkg::COMB_MATCH;
  endtask
  task automatic walk_limit();
    @(posedge clock);
    clear_cfg();
    ctr_cfg[0].auto_limit <= 1'b1;
    match_value[0] <= 32'h00000003;
    ev_enable <= 16'h0001;
    match_event(0, 4'h0, 32'h00000001);
    ev_cfg[0].out_set <= 10'h003;
    ev_cfg[0].out_clr <= 10'h002;
    ev_cfg[0].irq_en <= 1'b1;
    out_res[1] <= evt_timer_pkg::RES_TOGGLE;
    restart();
    wait_fire(0);
    check("limit count", {count_hi, count_lo}, 0);
    check("set output", outs[0], 1);
    check("conflict out", outs[1], 1);
    check("irq pulse", irq_req, 1);
    wait_fire(0);
    check("conflict again", outs[1], 0);
  endtask
  task automatic bidir_state();
    @(posedge clock);
    clear_cfg();
    ctr_cfg[0].bidir <= 1'b1;
    ctr_cfg[0].auto_limit <= 1'b1;
    match_value[0] <= 32'h00000003;
    match_value[1] <= 32'h00000001;
    ev_enable <= 16'h0003;
    match_event(0, 4'h0, 32'h00000001);
    ev_cfg[0].state_load <= 1'b1;
    ev_cfg[0].next_state <= 5'h01;
    match_event(1, 4'h1, 32'h00000003);
    ev_cfg[1].dir_qual <= evt_timer_pkg::DIR_DOWN;
    ev_cfg[1].out_set <= 10'h004;
    restart();
    wait_fire(0);
    check("reverse dir", count_down[0], 1);
    check("reverse count", count_lo, 16'h0002);
    check("new state", state, 5'h01);
    check("up pass skipped", outs[2], 0);
    wait_fire(1);
    check("down pass out", outs[2], 1);
    repeat (12) @(posedge clock);
    #1;
    check("state kept", state, 5'h01);
  endtask
  task automatic halt_hold();
    @(posedge clock);
    clear_cfg();
    ctr_cfg[0].auto_limit <= 1'b1;
    match_value[0] <= 32'h00000005;
    ev_enable <= 16'h0001;
    match_event(0, 4'h0, 32'h00000001);
    ev_cfg[0].act_halt <= 1'b1;
    restart();
    wait_fire(0);
    check("halt", {halted[0], running[0]}, 2'b10);
    @(posedge clock);
    sw_start <= 2'h1;
    @(posedge clock);
    sw_start <= 2'h0;
    repeat (3) @(posedge clock);
    #1;
    check("start ignored", {running[0], count_lo}, 17'h00000);
    @(posedge clock);
    halt_release <= 2'h1;
    ev_enable <= 16'h0000;
    @(posedge clock);
    halt_release <= 2'h0;
    sw_start <= 2'h1;
    @(posedge clock);
    sw_start <= 2'h0;
    #1;
    check("released run", running[0], 1);
  endtask
  task automatic input_capture();
    @(posedge clock);
    clear_cfg();
    ctr_cfg[0].clk_sel <= 1'b1;
    cap_mode <= 16'h0020;
    ev_enable <= 16'h0002;
    ev_cfg[1].state_mask <= 32'h00000001;
    ev_cfg[1].io_sel <= 5'h01;
    ev_cfg[1].io_cond <= evt_timer_pkg::IO_RISE;
    ev_cfg[1].comb <= evt_timer_pkg::COMB_IO;
    ev_cfg[1].cap_mask <= 16'h0020;
    ev_cfg[1].dma_en <= 1'b1;
    restart();
    repeat (3) pins.pulse(0);
    check("input clocked", {count_hi, count_lo}, 3);
    fork
      pins.pulse(1);
      begin
        wait_fire(1);
        check("capture", capture_value[5], 3);
        check("dma pulse", dma_req, 1);
      end
    join
  endtask
  task automatic split_halves();
    @(posedge clock);
    clear_cfg();
    unify <= 1'b0;
    match_value[1] <= 32'h00020000;
    ev_enable <= 16'h0001;
    match_event(0, 4'h1, 32'h00000001);
    ev_cfg[0].ctr_sel <= 1'b1;
    ev_cfg[0].act_stop <= 1'b1;
    restart();
    wait_fire(0);
    repeat (2) @(posedge clock);
    #1;
    check("split halves", {count_hi, count_lo}, 32'h00030005);
    check("stopped half", running, 2'b01);
  endtask
  initial
  begin
    clear_cfg();
    walk_limit();
    bidir_state();
    halt_hold();
    input_capture();
    split_halves();
    final_report();
  end
endmodule

// ### hw/evt_timer_consts.svh
// Purpose: Shared constants of the state/event PWM timer.
// Assumes: One system clock; all configuration arrives on plain ports.
// Notes:   Included by the package and by the top module; guarded.
//
// Operation
// - Counter runs as one 32-bit counter or two independent 16-bit halves.
// - Each counter counts up only, or up then down in bidirectional mode.
// - Counter advances on system clock or on rising edges of a chosen input.
// - Pool of sixteen registers, each set to match or capture.
// - Every output, capture, state and request action comes from events only; counters also take software start and auto limit.
// - Event is a match, an input/output edge or level, or a combination.
// - Enabled events stop or halt their counter; their start action never takes effect, as events fire only while the counter runs.
// - Limit clears a one-way counter and reverses a bidirectional one.
// - Match register zero can limit its counter automatically.
// - Any event can set, clear or toggle any output.
// - Triggering event copies the count into the capture registers it selects.
// - Events change state, toggle outputs, request interrupts and DMA.
// - Events can be qualified by count direction in bidirectional mode.
// - A match can be held pending until a later input/output condition.
// - Events occur only in their assigned states while the counter runs.
// - A firing event loads the state variable with its configured next state.
// - State keeps its value across counter wrap and limit.
// - Matches driving outputs give ten single-edge or seven dual-edge PWM outputs.
`ifndef EVT_TIMER_CONSTS_SVH
`define EVT_TIMER_CONSTS_SVH

// --------------------------------------------------------------------------
// Sizes
// --------------------------------------------------------------------------
`define ST_NUM_IN      8
`define ST_NUM_OUT     10
`define ST_NUM_MC      16
`define ST_NUM_EV      16
`define ST_NUM_STATE   32
`define ST_STATE_W     5
`define ST_IO_W        5
`define ST_IN_SEL_W    3
`define ST_HALF_W      16
`define ST_CNT_W       32

// --------------------------------------------------------------------------
// Values
// --------------------------------------------------------------------------
`define ST_AUTO_LIMIT_REG 4'h0
`define ST_MAX32          32'hffffffff
`define ST_MAX16          32'h0000ffff
`define ST_OUT_RESET      10'h000
`define ST_STATE_RESET    5'h00
`define ST_HALT_RESET     2'h3

`endif

// ### hw/evt_timer_pkg.sv
// Purpose: Types shared by the state/event PWM timer.
// Assumes: Constants header is on the include path.
// Notes:   Struct widths follow the header sizes.
`include "evt_timer_consts.svh"

package evt_timer_pkg;

  // ------------------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------------------
  typedef enum logic [1:0] {IO_LOW, IO_RISE, IO_FALL, IO_HIGH} io_cond_t;
  typedef enum logic [1:0] {COMB_OR, COMB_MATCH, COMB_IO, COMB_AND} comb_t;
  typedef enum logic [1:0] {DIR_ANY, DIR_UP, DIR_DOWN, DIR_ANY_ALT} dir_qual_t;
  typedef enum logic [1:0] {RES_NONE, RES_SET, RES_CLEAR, RES_TOGGLE} out_res_t;

  // ------------------------------------------------------------------------
  // Configuration carriers
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic [`ST_NUM_STATE-1:0] state_mask;
    logic [3:0]               match_sel;
    logic                     match_en;
    logic                     hold_match;
    logic [`ST_IO_W-1:0]      io_sel;
    io_cond_t                 io_cond;
    comb_t                    comb;
    dir_qual_t                dir_qual;
    logic                     ctr_sel;
    logic                     state_load;
    logic [`ST_STATE_W-1:0]   next_state;
    logic                     act_start;
    logic                     act_stop;
    logic                     act_halt;
    logic                     act_limit;
    logic [`ST_NUM_OUT-1:0]   out_set;
    logic [`ST_NUM_OUT-1:0]   out_clr;
    logic [`ST_NUM_OUT-1:0]   out_tgl;
    logic [`ST_NUM_MC-1:0]    cap_mask;
    logic                     irq_en;
    logic                     dma_en;
  } ev_cfg_t;

  typedef struct packed {
    logic                    bidir;
    logic                    clk_sel;
    logic [`ST_IN_SEL_W-1:0] clk_in_sel;
    logic                    auto_limit;
  } ctr_cfg_t;

endpackage

// ### hw/io_sync.sv
// Purpose: Three-stage synchroniser with edge pulses for the timer inputs.
// Assumes: Inputs are asynchronous to clock.
// Notes:   A change is accepted only once stages two and three agree.
`timescale 1ns/100ps

module io_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Raw pins
  input  wire logic [W-1:0] din,
  // Filtered view
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_next;

  // Keep the old level while the late stages disagree
  assign lvl_next = (lvl & ~(s2_reg ^ s3_reg)) ^ ((s2_reg ^ s3_reg) & lvl) ^ (~(s2_reg ^ s3_reg) & (s3_reg ^ lvl));

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl    <= '0;
      rise   <= '0;
      fall   <= '0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl    <= lvl_next;
      rise   <= lvl_next & ~lvl;
      fall   <= ~lvl_next & lvl;
    end
  end

endmodule

// ### hw/state_event_pwm_timer.sv
// Purpose: Event-driven state timer producing PWM outputs and captures.
// Assumes: Configuration ports are quasi-static and on the clock domain.
// Notes:   One state variable is shared by both halves in split mode.
`timescale 1ns/100ps
`include "evt_timer_consts.svh"

module state_event_pwm_timer #(
  parameter int N_EV = `ST_NUM_EV
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rstn,
  // Counter configuration and software control
  input  wire logic                          unify,
  input  wire evt_timer_pkg::ctr_cfg_t       ctr_cfg [2],
  input  wire logic [1:0]                    sw_start,
  input  wire logic [1:0]                    halt_release,
  // Event configuration
  input  wire logic [N_EV-1:0]               ev_enable,
  input  wire evt_timer_pkg::ev_cfg_t        ev_cfg [N_EV],
  // Match/capture pool
  input  wire logic [`ST_NUM_MC-1:0]         cap_mode,
  input  wire logic [`ST_CNT_W-1:0]          match_value [`ST_NUM_MC],
  // Output conflict rule
  input  wire evt_timer_pkg::out_res_t       out_res [`ST_NUM_OUT],
  // Pins
  input  wire logic [`ST_NUM_IN-1:0]         ins,
  output logic      [`ST_NUM_OUT-1:0]        outs,
  // Status
  output logic      [`ST_HALF_W-1:0]         count_lo,
  output logic      [`ST_HALF_W-1:0]         count_hi,
  output logic      [1:0]                    count_down,
  output logic      [1:0]                    running,
  output logic      [1:0]                    halted,
  output logic      [`ST_STATE_W-1:0]        state,
  output logic      [`ST_CNT_W-1:0]          capture_value [`ST_NUM_MC],
  output logic      [N_EV-1:0]               event_fired,
  output logic                               irq_req,
  output logic                               dma_req
);

  localparam int NIO = `ST_NUM_IN + `ST_NUM_OUT;

  // ------------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------------
  // Returns {direction_down, next_count}
  function automatic logic [32:0] cnt_step(input logic [31:0] cur, input logic down,
                                           input logic bidir, input logic lim, input logic [31:0] maxv);
    logic [32:0] r;
    r = {1'b0, cur};
    if (!bidir)
    begin
      if (lim || cur == maxv)
        r = {1'b0, 32'h00000000};
      else
        r = {1'b0, 32'(cur + 32'h00000001)};
    end
    else if (!down)
    begin
      if (lim || cur == maxv)
        r = {1'b1, 32'(cur - 32'h00000001)};
      else
        r = {1'b0, 32'(cur + 32'h00000001)};
    end
    else
    begin
      if (lim || cur == 32'h00000000)
        r = {1'b0, 32'(cur + 32'h00000001)};
      else
        r = {1'b1, 32'(cur - 32'h00000001)};
    end
    return r;
  endfunction

  // Match register as seen by one half
  function automatic logic [31:0] mview(input logic [31:0] mv, input logic uni, input logic h);
    logic [31:0] r;
    r = mv;
    if (!uni)
      r = h ? {16'h0000, mv[31:16]} : {16'h0000, mv[15:0]};
    return r;
  endfunction

  // ------------------------------------------------------------------------
  // Input synchronisation and I/O view
  // ------------------------------------------------------------------------
  logic [`ST_NUM_IN-1:0]  in_lvl;
  logic [`ST_NUM_IN-1:0]  in_rise;
  logic [`ST_NUM_IN-1:0]  in_fall;
  logic [`ST_NUM_OUT-1:0] out_reg;
  logic [`ST_NUM_OUT-1:0] out_next;
  logic [`ST_NUM_OUT-1:0] out_prev_reg;
  logic [NIO-1:0]         io_lvl;
  logic [NIO-1:0]         io_rise;
  logic [NIO-1:0]         io_fall;

  io_sync #(.W(`ST_NUM_IN)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   (ins),
    .lvl   (in_lvl),
    .rise  (in_rise),
    .fall  (in_fall)
  );

  // Outputs can qualify events too, so their edges are tracked here
  assign io_lvl  = {out_reg, in_lvl};
  assign io_rise = {out_reg & ~out_prev_reg, in_rise};
  assign io_fall = {~out_reg & out_prev_reg, in_fall};

  // ------------------------------------------------------------------------
  // Counter state
  // ------------------------------------------------------------------------
  logic [1:0]  run_reg;
  logic [1:0]  halt_reg;
  logic [1:0]  dir_reg;
  logic [1:0]  fresh_reg;
  logic [1:0]  limpend_reg;
  logic [15:0] lo_reg;
  logic [15:0] hi_reg;
  logic [1:0]  run_ok;
  logic [1:0]  tick_en;
  logic [1:0]  tick;
  logic [1:0]  lim_eff;
  logic [1:0]  auto_lim;
  logic [31:0] view [2];
  logic [32:0] u_step;
  logic [32:0] lo_step;
  logic [32:0] hi_step;

  assign view[0] = unify ? {hi_reg, lo_reg} : {16'h0000, lo_reg};
  assign view[1] = unify ? {hi_reg, lo_reg} : {16'h0000, hi_reg};

  // In unified mode half one mirrors the controls of half zero
  assign run_ok[0]  = run_reg[0] & ~halt_reg[0];
  assign run_ok[1]  = unify ? run_ok[0] : (run_reg[1] & ~halt_reg[1]);
  assign tick_en[0] = ctr_cfg[0].clk_sel ? in_rise[ctr_cfg[0].clk_in_sel] : 1'b1;
  assign tick_en[1] = ctr_cfg[1].clk_sel ? in_rise[ctr_cfg[1].clk_in_sel] : 1'b1;
  assign tick[0]    = run_ok[0] & tick_en[0];
  assign tick[1]    = unify ? tick[0] : (run_ok[1] & tick_en[1]);

  // Auto limit on match register zero, only while it serves as a match
  assign auto_lim[0] = ctr_cfg[0].auto_limit & ~cap_mode[0] & fresh_reg[0] &
                       (mview(match_value[`ST_AUTO_LIMIT_REG], unify, 1'b0) == view[0]);
  assign auto_lim[1] = ~unify & ctr_cfg[1].auto_limit & ~cap_mode[0] & fresh_reg[1] &
                       (mview(match_value[`ST_AUTO_LIMIT_REG], unify, 1'b1) == view[1]);

  // ------------------------------------------------------------------------
  // Event evaluation
  // ------------------------------------------------------------------------
  logic [N_EV-1:0] fire;
  logic [N_EV-1:0] mhit;
  logic [N_EV-1:0] pend_reg;
  logic [N_EV-1:0] pend_next;
  logic [N_EV-1:0] evh;

  for (genvar e = 0; e < N_EV; e++)
  begin : g_ev
    logic io_on;
    logic m_on;
    logic raw;
    logic dir_ok;
    logic io_valid;

    assign evh[e]   = unify ? 1'b0 : ev_cfg[e].ctr_sel;
    assign io_valid = (ev_cfg[e].io_sel < `ST_IO_W'(NIO));
    assign mhit[e]  = ev_cfg[e].match_en & ~cap_mode[ev_cfg[e].match_sel] & fresh_reg[evh[e]] &
                      (mview(match_value[ev_cfg[e].match_sel], unify, evh[e]) == view[evh[e]]);
    assign io_on    = io_valid & (
                      (ev_cfg[e].io_cond == evt_timer_pkg::IO_LOW)  ? ~io_lvl[ev_cfg[e].io_sel] :
                      (ev_cfg[e].io_cond == evt_timer_pkg::IO_RISE) ?  io_rise[ev_cfg[e].io_sel] :
                      (ev_cfg[e].io_cond == evt_timer_pkg::IO_FALL) ?  io_fall[ev_cfg[e].io_sel] :
                                                                        io_lvl[ev_cfg[e].io_sel]);
    // A held match waits for the I/O condition instead of firing at once
    assign m_on     = mhit[e] | (ev_cfg[e].hold_match & pend_reg[e]);
    assign raw      = ev_cfg[e].hold_match ? (m_on & io_on) :
                      (ev_cfg[e].comb == evt_timer_pkg::COMB_OR)    ? (mhit[e] | io_on) :
                      (ev_cfg[e].comb == evt_timer_pkg::COMB_MATCH) ? mhit[e] :
                      (ev_cfg[e].comb == evt_timer_pkg::COMB_IO)    ? io_on :
                                                                       (mhit[e] & io_on);
    assign dir_ok   = ~ctr_cfg[evh[e]].bidir | (
                      (ev_cfg[e].dir_qual == evt_timer_pkg::DIR_UP)   ? ~dir_reg[evh[e]] :
                      (ev_cfg[e].dir_qual == evt_timer_pkg::DIR_DOWN) ?  dir_reg[evh[e]] : 1'b1);
    assign fire[e]  = ev_enable[e] & raw & dir_ok & ev_cfg[e].state_mask[state] & run_ok[evh[e]];
    // A match arriving with its own firing does not re-arm the hold
    assign pend_next[e] = ev_cfg[e].hold_match & (mhit[e] | pend_reg[e]) & ~fire[e];
  end

  // ------------------------------------------------------------------------
  // Action gathering
  // ------------------------------------------------------------------------
  logic [1:0]             start_req;
  logic [1:0]             stop_req;
  logic [1:0]             halt_req;
  logic [1:0]             lim_req;
  logic [`ST_NUM_OUT-1:0] set_req;
  logic [`ST_NUM_OUT-1:0] clr_req;
  logic [`ST_NUM_OUT-1:0] tgl_req;
  logic [`ST_NUM_MC-1:0]  cap_hit;
  logic [31:0]            cap_src [`ST_NUM_MC];
  logic [`ST_STATE_W-1:0] state_next;
  logic                   irq_next;
  logic                   dma_next;

  always_comb
  begin
    start_req  = 2'b00;
    stop_req   = 2'b00;
    halt_req   = 2'b00;
    lim_req    = 2'b00;
    set_req    = '0;
    clr_req    = '0;
    tgl_req    = '0;
    cap_hit    = '0;
    state_next = state;
    irq_next   = 1'b0;
    dma_next   = 1'b0;
    for (int i = 0; i < `ST_NUM_MC; i++)
      cap_src[i] = capture_value[i];
    // Higher-numbered events win on state and capture source
    for (int e = 0; e < N_EV; e++)
    begin
      if (fire[e])
      begin
        start_req[evh[e]] = start_req[evh[e]] | ev_cfg[e].act_start;
        stop_req[evh[e]]  = stop_req[evh[e]]  | ev_cfg[e].act_stop;
        halt_req[evh[e]]  = halt_req[evh[e]]  | ev_cfg[e].act_halt;
        lim_req[evh[e]]   = lim_req[evh[e]]   | ev_cfg[e].act_limit;
        set_req  = set_req | ev_cfg[e].out_set;
        clr_req  = clr_req | ev_cfg[e].out_clr;
        tgl_req  = tgl_req | ev_cfg[e].out_tgl;
        irq_next = irq_next | ev_cfg[e].irq_en;
        dma_next = dma_next | ev_cfg[e].dma_en;
        if (ev_cfg[e].state_load)
          state_next = ev_cfg[e].next_state;
        for (int i = 0; i < `ST_NUM_MC; i++)
        begin
          if (ev_cfg[e].cap_mask[i] && cap_mode[i])
          begin
            cap_hit[i] = 1'b1;
            cap_src[i] = view[evh[e]];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------------
  // Output resolution
  // ------------------------------------------------------------------------
  for (genvar o = 0; o < `ST_NUM_OUT; o++)
  begin : g_out
    logic both;
    logic res_val;
    assign both    = set_req[o] & clr_req[o];
    assign res_val = (out_res[o] == evt_timer_pkg::RES_SET)    ? 1'b1 :
                     (out_res[o] == evt_timer_pkg::RES_CLEAR)  ? 1'b0 :
                     (out_res[o] == evt_timer_pkg::RES_TOGGLE) ? ~out_reg[o] : out_reg[o];
    // Set and clear at different matches shape single- or dual-edge PWM
    assign out_next[o] = both       ? res_val :
                         set_req[o] ? 1'b1 :
                         clr_req[o] ? 1'b0 :
                         tgl_req[o] ? ~out_reg[o] : out_reg[o];
  end

  // ------------------------------------------------------------------------
  // Counting
  // ------------------------------------------------------------------------
  assign lim_eff[0] = lim_req[0] | auto_lim[0] | limpend_reg[0];
  assign lim_eff[1] = lim_req[1] | auto_lim[1] | limpend_reg[1];
  assign u_step  = cnt_step({hi_reg, lo_reg}, dir_reg[0], ctr_cfg[0].bidir, lim_eff[0], `ST_MAX32);
  assign lo_step = cnt_step({16'h0000, lo_reg}, dir_reg[0], ctr_cfg[0].bidir, lim_eff[0], `ST_MAX16);
  assign hi_step = cnt_step({16'h0000, hi_reg}, dir_reg[1], ctr_cfg[1].bidir, lim_eff[1], `ST_MAX16);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      lo_reg  <= 16'h0000;
      hi_reg  <= 16'h0000;
      dir_reg <= 2'b00;
    end
    else if (unify)
    begin
      if (tick[0])
      begin
        {hi_reg, lo_reg} <= u_step[31:0];
        dir_reg          <= {u_step[32], u_step[32]};
      end
    end
    else
    begin
      if (tick[0])
      begin
        lo_reg     <= lo_step[15:0];
        dir_reg[0] <= lo_step[32];
      end
      if (tick[1])
      begin
        hi_reg     <= hi_step[15:0];
        dir_reg[1] <= hi_step[32];
      end
    end
  end

  // Run control: stop beats start; halt beats release and blocks start
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      run_reg     <= 2'b00;
      halt_reg    <= `ST_HALT_RESET;
      fresh_reg   <= 2'b00;
      limpend_reg <= 2'b00;
    end
    else
    begin
      for (int h = 0; h < 2; h++)
      begin
        if (stop_req[h] | halt_req[h])
          run_reg[h] <= 1'b0;
        else if ((start_req[h] | sw_start[h]) & ~halt_reg[h])
          run_reg[h] <= 1'b1;
        halt_reg[h]    <= halt_req[h] | (halt_reg[h] & ~halt_release[h]);
        limpend_reg[h] <= (lim_req[h] | auto_lim[h] | limpend_reg[h]) & ~tick[h];
      end
      fresh_reg <= tick;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs, state, captures, requests
  // ------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      out_reg      <= `ST_OUT_RESET;
      out_prev_reg <= `ST_OUT_RESET;
      state        <= `ST_STATE_RESET;
      pend_reg     <= '0;
      event_fired  <= '0;
      irq_req      <= 1'b0;
      dma_req      <= 1'b0;
      for (int i = 0; i < `ST_NUM_MC; i++)
        capture_value[i] <= 32'h00000000;
    end
    else
    begin
      out_reg      <= out_next;
      out_prev_reg <= out_reg;
      state        <= state_next;
      pend_reg     <= pend_next;
      event_fired  <= fire;
      irq_req      <= irq_next;
      dma_req      <= dma_next;
      for (int i = 0; i < `ST_NUM_MC; i++)
        if (cap_hit[i])
          capture_value[i] <= cap_src[i];
    end
  end

  assign outs       = out_reg;
  assign count_lo   = lo_reg;
  assign count_hi   = hi_reg;
  assign count_down = dir_reg;
  assign running    = run_ok;
  assign halted     = unify ? {halt_reg[0], halt_reg[0]} : halt_reg;

endmodule
